/* File: crank_angle_tracker_consts.svh */
// offsets, field positions, reset values and sizes for the crank angle tracker
`ifndef CRANK_ANGLE_TRACKER_CONSTS_SVH
`define CRANK_ANGLE_TRACKER_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 6'h00
`define OFS_RATIO 6'h04
`define OFS_TEETH_EXPECT 6'h08
`define OFS_TEETH_LIMIT 6'h0C
`define OFS_CAM_PATTERN 6'h10
`define OFS_BANK 6'h14
`define OFS_ANGLE 6'h18
`define OFS_PERIOD 6'h1C
`define OFS_RISE_ANGLE 6'h20
`define OFS_FALL_ANGLE 6'h24
`define OFS_FALL_DELAY 6'h28
`define OFS_STATUS 6'h2C
`define OFS_MASK 6'h30

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_ADDITIONAL 1
`define CTRL_FALL_BY_TIME 2
`define CTRL_PULSE_ARM 3
`define CTRL_W 4

// ----------------------------------------------------------------------------
// status / mask fields
// ----------------------------------------------------------------------------
`define ST_SPECIAL_ERR 0
`define ST_REGULAR_ERR 1
`define ST_SPECIAL 2
`define ST_REFERENCE 3
`define ST_W 4

// ----------------------------------------------------------------------------
// reset values and fixed sizes
// ----------------------------------------------------------------------------
`define RATIO_FRAC_BITS 8
`define RATIO_RESET 16'h0180
`define TEETH_EXPECT_RESET 16'h003A
`define TEETH_LIMIT_RESET 16'h003A
`define CAM_PATTERN_RESET 8'h01
`define FRAC_MAX 8'hFF
`define FRAC_STEP 24'h000100

`endif

/* File: crank_angle_tracker_pkg.sv */
// types shared by the crank angle tracker
package crank_angle_tracker_pkg;

  // one qualified crank tooth, as seen by the tooth tracker
  typedef struct packed {
    logic special;
    logic regular;
    logic [15:0] period;
  } tooth_evt_t;

  // angle position: whole teeth and 1/256 tooth extrapolated fraction
  typedef struct packed {
    logic [15:0] tooth;
    logic [7:0] frac;
  } angle_pos_t;

  typedef enum logic [0:0] {
    PULSE_LOW = 1'b0,
    PULSE_HIGH = 1'b1
  } pulse_state_t;

endpackage : crank_angle_tracker_pkg

/* File: crank_angle_tracker.sv */
// crank angle tracker: tooth tracking, bank reference, angle pulses, noise checks
// Summary of operation
// - cam pattern increments the bank count
// - after bank switch, next special resets angle
// - track angle by teeth plus extrapolation
// - extrapolate with last two teeth's period
// - missing: period exceeds previous times ratio
// - additional: period below previous times ratio
// - ratio may change anytime, next test uses
// - both variants, any number of special teeth
// - rising pulse edge at programmed angle
// - falling edge at angle or after delay
// - special tooth needs exact regular count
// - regular count must not exceed limit
// - failed check raises host interrupt
`timescale 1ns/1ns
`include "crank_angle_tracker_consts.svh"

module crank_angle_tracker #(
  parameter int TB_W = 16 // timebase width
) (
  input wire logic i_clk, // 10 MHz system clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_wb_cyc, // wishbone cycle
  input wire logic i_wb_stb, // wishbone strobe
  input wire logic i_wb_we, // wishbone write enable
  input wire logic [5:0] i_wb_adr, // wishbone byte address
  input wire logic [3:0] i_wb_sel, // wishbone byte selects
  input wire logic [31:0] i_wb_dat, // wishbone write data
  output logic [31:0] o_wb_dat, // wishbone read data
  output logic o_wb_ack, // wishbone acknowledge
  input wire logic i_crank, // conditioned crank tooth signal
  input wire logic i_cam, // conditioned cam marker signal
  output logic o_pulse, // ignition or injection pulse
  output logic o_irq, // level interrupt request
  output crank_angle_tracker_pkg::angle_pos_t o_angle // current engine angle
);
  import crank_angle_tracker_pkg::*;

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wr[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_sel

  // special tooth test against previous period scaled by ratio
  function automatic logic ratio_hit(input logic [15:0] cur, input logic [15:0] prev,
                                     input logic [15:0] ratio, input logic additional);
    logic [31:0] scaled_cur;
    logic [31:0] scaled_prev;
    scaled_cur = {8'h00, cur, 8'h00};
    scaled_prev = prev * ratio;
    if (additional) begin
      return scaled_cur < scaled_prev;
    end
    return scaled_cur > scaled_prev;
  endfunction : ratio_hit

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [`CTRL_W-1:0] ctrl;
  logic [15:0] ratio;
  logic [15:0] teeth_expect;
  logic [15:0] teeth_limit;
  logic [7:0] cam_pattern;
  logic [7:0] bank;
  logic [15:0] rise_angle_tooth;
  logic [7:0] rise_angle_frac;
  logic [15:0] fall_angle_tooth;
  logic [7:0] fall_angle_frac;
  logic [23:0] fall_delay;
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr = bus_req & i_wb_we;
  wire wr_ctrl = bus_wr && i_wb_adr == `OFS_CTRL;
  wire wr_ratio = bus_wr && i_wb_adr == `OFS_RATIO;
  wire wr_expect = bus_wr && i_wb_adr == `OFS_TEETH_EXPECT;
  wire wr_limit = bus_wr && i_wb_adr == `OFS_TEETH_LIMIT;
  wire wr_cam = bus_wr && i_wb_adr == `OFS_CAM_PATTERN;
  wire wr_rise = bus_wr && i_wb_adr == `OFS_RISE_ANGLE;
  wire wr_fall = bus_wr && i_wb_adr == `OFS_FALL_ANGLE;
  wire wr_delay = bus_wr && i_wb_adr == `OFS_FALL_DELAY;
  wire wr_status = bus_wr && i_wb_adr == `OFS_STATUS;
  wire wr_mask = bus_wr && i_wb_adr == `OFS_MASK;

  wire [31:0] cur_ctrl = {{(32-`CTRL_W){1'b0}}, ctrl};
  wire [31:0] cur_ratio = {16'h0000, ratio};
  wire [31:0] cur_expect = {16'h0000, teeth_expect};
  wire [31:0] cur_limit = {16'h0000, teeth_limit};
  wire [31:0] cur_cam = {24'h000000, cam_pattern};
  wire [31:0] cur_rise = {8'h00, rise_angle_tooth, rise_angle_frac};
  wire [31:0] cur_fall = {8'h00, fall_angle_tooth, fall_angle_frac};
  wire [31:0] cur_delay = {8'h00, fall_delay};
  wire [31:0] cur_mask = {{(32-`ST_W){1'b0}}, mask};
  wire [31:0] cur_status = {{(32-`ST_W){1'b0}}, status};

  wire [31:0] new_ctrl = merge_sel(cur_ctrl, i_wb_dat, i_wb_sel);
  wire [31:0] new_ratio = merge_sel(cur_ratio, i_wb_dat, i_wb_sel);
  wire [31:0] new_expect = merge_sel(cur_expect, i_wb_dat, i_wb_sel);
  wire [31:0] new_limit = merge_sel(cur_limit, i_wb_dat, i_wb_sel);
  wire [31:0] new_cam = merge_sel(cur_cam, i_wb_dat, i_wb_sel);
  wire [31:0] new_rise = merge_sel(cur_rise, i_wb_dat, i_wb_sel);
  wire [31:0] new_fall = merge_sel(cur_fall, i_wb_dat, i_wb_sel);
  wire [31:0] new_delay = merge_sel(cur_delay, i_wb_dat, i_wb_sel);
  wire [31:0] new_mask = merge_sel(cur_mask, i_wb_dat, i_wb_sel);
  wire [`ST_W-1:0] clr_status = wr_status ? i_wb_dat[`ST_W-1:0] & {`ST_W{i_wb_sel[0]}} :
                                            {`ST_W{1'b0}};

  // ----------------------------------------------------------------------------
  // tooth tracker: edges and periods
  // ----------------------------------------------------------------------------
  logic [TB_W-1:0] timebase;
  logic [TB_W-1:0] last_edge_time;
  logic [15:0] period;
  logic [15:0] prev_period;
  logic crank_d;
  logic cam_d;
  logic first_edge_seen;
  logic have_prev;
  logic [15:0] regular_count;
  logic bank_flag;
  logic ref_seen;
  logic [7:0] cam_count;

  wire enabled = ctrl[`CTRL_ENABLE];
  wire crank_rise = enabled & i_crank & ~crank_d;
  wire cam_rise = enabled & i_cam & ~cam_d;
  wire [15:0] new_period = 16'(timebase - last_edge_time);
  // ratio is sampled live, so a host update steers the very next test
  wire is_special = have_prev &
                    ratio_hit(new_period, period, ratio, ctrl[`CTRL_ADDITIONAL]);
  tooth_evt_t tooth;
  assign tooth.special = crank_rise & first_edge_seen & is_special;
  assign tooth.regular = crank_rise & first_edge_seen & ~is_special;
  assign tooth.period = new_period;

  wire [15:0] next_regular = regular_count + 16'h0001;
  wire special_err = tooth.special & (regular_count != teeth_expect);
  wire regular_err = tooth.regular & (next_regular > teeth_limit);
  wire cam_match = cam_rise & (cam_count + 8'h01 >= cam_pattern);
  wire take_ref = tooth.special & bank_flag;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      timebase <= '0;
      last_edge_time <= '0;
      period <= 16'h0000;
      prev_period <= 16'h0000;
      crank_d <= 1'b0;
      cam_d <= 1'b0;
      first_edge_seen <= 1'b0;
      have_prev <= 1'b0;
    end else begin
      timebase <= timebase + 1'b1;
      crank_d <= i_crank;
      cam_d <= i_cam;
      if (crank_rise) begin
        last_edge_time <= timebase;
        first_edge_seen <= 1'b1;
        if (first_edge_seen) begin
          prev_period <= period;
          period <= new_period;
          have_prev <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // noise checks, bank and reference
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      regular_count <= 16'h0000;
      cam_count <= 8'h00;
      bank <= 8'h00;
      bank_flag <= 1'b0;
      ref_seen <= 1'b0;
    end else begin
      if (tooth.special) begin
        regular_count <= 16'h0000;
      end else if (tooth.regular) begin
        regular_count <= next_regular;
      end
      if (cam_match) begin
        cam_count <= 8'h00;
        bank <= bank + 8'h01;
      end else if (cam_rise) begin
        cam_count <= cam_count + 8'h01;
      end
      // a cam match in the same cycle as a reference re-arms the flag
      if (cam_match) begin
        bank_flag <= 1'b1;
      end else if (take_ref) begin
        bank_flag <= 1'b0;
      end
      if (take_ref) begin
        ref_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // angle counter with extrapolation
  // ----------------------------------------------------------------------------
  angle_pos_t pos;
  logic [23:0] frac_acc;
  wire [23:0] frac_sum = frac_acc + `FRAC_STEP;
  wire frac_step = (period != 16'h0000) && (frac_sum >= {8'h00, period});

  // fraction advances 256 steps per last tooth period, at most one a clock; capped so it never
  // runs into the next tooth when the engine slows down
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pos <= '0;
      frac_acc <= 24'h000000;
    end else if (take_ref) begin
      pos <= '0;
      frac_acc <= 24'h000000;
    end else if (tooth.special | tooth.regular) begin
      pos.tooth <= pos.tooth + 16'h0001;
      pos.frac <= 8'h00;
      frac_acc <= 24'h000000;
    end else if (frac_step) begin
      frac_acc <= frac_sum - {8'h00, period};
      if (pos.frac != `FRAC_MAX) begin
        pos.frac <= pos.frac + 8'h01;
      end
    end else begin
      frac_acc <= frac_sum;
    end
  end

  // ----------------------------------------------------------------------------
  // angle pulse generator
  // ----------------------------------------------------------------------------
  pulse_state_t pulse_state;
  logic [23:0] delay_count;
  wire at_rise = ref_seen && pos == {rise_angle_tooth, rise_angle_frac};
  wire at_fall = pos == {fall_angle_tooth, fall_angle_frac};
  wire fall_now = ctrl[`CTRL_FALL_BY_TIME] ? (delay_count + 24'h000001 >= fall_delay) : at_fall;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pulse_state <= PULSE_LOW;
      delay_count <= 24'h000000;
    end else begin
      unique case (pulse_state)
        PULSE_LOW: begin
          delay_count <= 24'h000000;
          if (ctrl[`CTRL_PULSE_ARM] && at_rise) begin
            pulse_state <= PULSE_HIGH;
          end
        end
        PULSE_HIGH: begin
          delay_count <= delay_count + 24'h000001;
          if (fall_now) begin
            pulse_state <= PULSE_LOW;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // register writes, status and interrupt
  // ----------------------------------------------------------------------------
  wire [`ST_W-1:0] events = {take_ref, tooth.special, regular_err, special_err};

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl <= '0;
      ratio <= `RATIO_RESET;
      teeth_expect <= `TEETH_EXPECT_RESET;
      teeth_limit <= `TEETH_LIMIT_RESET;
      cam_pattern <= `CAM_PATTERN_RESET;
      rise_angle_tooth <= 16'h0000;
      rise_angle_frac <= 8'h00;
      fall_angle_tooth <= 16'h0000;
      fall_angle_frac <= 8'h00;
      fall_delay <= 24'h000000;
      status <= '0;
      mask <= '0;
    end else begin
      if (wr_ctrl) ctrl <= new_ctrl[`CTRL_W-1:0];
      if (wr_ratio) ratio <= new_ratio[15:0];
      if (wr_expect) teeth_expect <= new_expect[15:0];
      if (wr_limit) teeth_limit <= new_limit[15:0];
      if (wr_cam) cam_pattern <= new_cam[7:0];
      if (wr_rise) {rise_angle_tooth, rise_angle_frac} <= new_rise[23:0];
      if (wr_fall) {fall_angle_tooth, fall_angle_frac} <= new_fall[23:0];
      if (wr_delay) fall_delay <= new_delay[23:0];
      if (wr_mask) mask <= new_mask[`ST_W-1:0];
      status <= (status & ~clr_status) | events;
    end
  end

  // ----------------------------------------------------------------------------
  // bus answer and outputs
  // ----------------------------------------------------------------------------
  logic [31:0] rd_data;
  always_comb begin
    unique case (i_wb_adr)
      `OFS_CTRL: rd_data = cur_ctrl;
      `OFS_RATIO: rd_data = cur_ratio;
      `OFS_TEETH_EXPECT: rd_data = cur_expect;
      `OFS_TEETH_LIMIT: rd_data = cur_limit;
      `OFS_CAM_PATTERN: rd_data = cur_cam;
      `OFS_BANK: rd_data = {16'h0000, 7'h00, bank_flag, bank};
      `OFS_ANGLE: rd_data = {7'h00, ref_seen, pos};
      `OFS_PERIOD: rd_data = {prev_period, period};
      `OFS_RISE_ANGLE: rd_data = cur_rise;
      `OFS_FALL_ANGLE: rd_data = cur_fall;
      `OFS_FALL_DELAY: rd_data = cur_delay;
      `OFS_STATUS: rd_data = cur_status;
      `OFS_MASK: rd_data = cur_mask;
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      o_irq <= 1'b0;
      o_pulse <= 1'b0;
      o_angle <= '0;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= (bus_req & ~i_wb_we) ? rd_data : 32'h00000000;
      // a mask write steers the level at once, so the bus edge is its cause
      o_irq <= |(((status & ~clr_status) | events) &
                 (wr_mask ? new_mask[`ST_W-1:0] : mask));
      o_pulse <= (pulse_state == PULSE_LOW) ? (ctrl[`CTRL_PULSE_ARM] & at_rise) : ~fall_now;
      o_angle <= pos;
    end
  end

endmodule : crank_angle_tracker

/* File: crank_angle_tracker_checker.sv */
// port-level assertion checker for the crank angle tracker
`timescale 1ns/1ns
module crank_angle_tracker_checker
  import crank_angle_tracker_pkg::*;
#(
  parameter int TB_W = 16 // timebase width
) (
  input wire logic i_clk, // clock
  input wire logic i_reset_n, // reset, active low
  input wire logic i_wb_cyc, // cycle
  input wire logic i_wb_stb, // strobe
  input wire logic i_wb_we, // write enable
  input wire logic [5:0] i_wb_adr, // address
  input wire logic [3:0] i_wb_sel, // lanes
  input wire logic [31:0] i_wb_dat, // write data
  input wire logic [31:0] o_wb_dat, // read data
  input wire logic o_wb_ack, // acknowledge
  input wire logic i_crank, // crank level
  input wire logic i_cam, // cam level
  input wire logic o_pulse, // angle pulse
  input wire logic o_irq, // interrupt
  input wire crank_angle_tracker_pkg::angle_pos_t o_angle // angle
);
  logic wr_take;
  assign wr_take = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_ack_next;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_dat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_reset_outs;
    $rose(i_reset_n) |-> !o_pulse && !o_irq && !o_wb_ack && o_angle == 24'h0;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("outputs not cleared");
  property p_irq_cause;
    $rose(o_irq) |-> ($past(i_crank) && !$past(i_crank, 2)) || $past(wr_take);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_irq_hold;
    o_irq && !wr_take |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_tooth_cause;
    $changed(o_angle.tooth) |-> $past(i_crank, 2) && !$past(i_crank, 3);
  endproperty
  a_tooth_cause: assert property (p_tooth_cause) else $error("angle moved alone");
  property p_tooth_step;
    $changed(o_angle.tooth) |-> o_angle.tooth == $past(o_angle.tooth) + 16'h1
      || o_angle.tooth == 16'h0;
  endproperty
  a_tooth_step: assert property (p_tooth_step) else $error("angle step wrong");
endmodule : crank_angle_tracker_checker

bind crank_angle_tracker crank_angle_tracker_checker #(.TB_W(TB_W)) chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_crank(i_crank), .i_cam(i_cam),
  .o_pulse(o_pulse), .o_irq(o_irq), .o_angle(o_angle));

/* File: tooth_wheel_model.sv */
// behavioural crank wheel and cam marker sensors
`timescale 1ns/1ns
module tooth_wheel_model #(
  parameter int GAP = 20, // cycles between regular teeth
  parameter int TEETH = 12 // tooth slots per revolution
) (
  input wire logic i_clk, // bench clock
  input wire logic i_run, // wheel turning
  input wire logic i_extra, // additional tooth wheel, else missing tooth
  output logic o_crank, // crank tooth level
  output logic o_cam // cam marker level
);
  int t = 0;
  int k = 0;
  int rev = 0;
  int glen;
  int last;
  // special slot either splits one gap in two or swallows a tooth
  assign glen = (k < TEETH - 1) ? GAP : (i_extra ? GAP / 2 : 2 * GAP);
  assign last = i_extra ? TEETH : TEETH - 1;
  initial o_crank = 1'b0;
  initial o_cam = 1'b0;
  always @(posedge i_clk) begin
    if (!i_run) begin
      t <= 0;
      k <= 0;
      o_crank <= 1'b0;
    end else if (t + 1 >= glen) begin
      t <= 0;
      o_crank <= 1'b1;
      k <= (k == last) ? 0 : k + 1;
      rev <= (k == last) ? rev + 1 : rev;
    end else begin
      t <= t + 1;
      if (t == 1) o_crank <= 1'b0;
    end
    // cam marker once every second revolution, clear of crank edges
    o_cam <= i_run && rev[0] && k == 4 && t > 5;
  end
endmodule : tooth_wheel_model

/* File: tb_crank_angle_tracker.sv */
// self-checking testbench for the crank angle tracker
`timescale 1ns/1ns
`include "crank_angle_tracker_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_crank_angle_tracker;
  import crank_angle_tracker_pkg::*;
  logic clk = 1'b0;
  logic reset_n, wb_cyc, wb_stb, wb_we, wb_ack, crank, cam, pulse, irq, run, extra;
  logic [5:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_q, q, rv;
  angle_pos_t angle;
  logic cr, cm, pc, pm;
  int err_count = 0;
  int num_checks = 0;
  int cyc_n, t_prev, per, per_old, n_edge, cnt, st, msk, ang, refd, bflag, bank;
  int ratio, expct, lim, addm, live, due, teeth_done;
  always #50 clk = ~clk;
  crank_angle_tracker #(.TB_W(16)) dut_u (.i_clk(clk), .i_reset_n(reset_n),
    .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
    .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(wb_q), .o_wb_ack(wb_ack),
    .i_crank(crank), .i_cam(cam), .o_pulse(pulse), .o_irq(irq), .o_angle(angle));
  tooth_wheel_model #(.GAP(20), .TEETH(12)) wheel_u (.i_clk(clk), .i_run(run),
    .i_extra(extra), .o_crank(crank), .o_cam(cam));
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // reference model of the tooth tracker
  // ---------------------------------------------------------------
  task automatic tooth();
    logic sp;
    n_edge++;
    if (n_edge >= 2) begin
      per_old = per;
      per = cyc_n - t_prev;
    end
    t_prev = cyc_n;
    sp = n_edge >= 3 && (addm ? per * 256 < per_old * ratio : per * 256 > per_old * ratio);
    if (sp) begin
      if (cnt != expct) st |= 1;
      cnt = 0;
      if (bflag) begin
        ang = 0;
        refd = 1;
        bflag = 0;
      end else ang++;
    end else begin
      cnt++;
      if (cnt > lim) st |= 2;
      ang++;
    end
    due = 1;
  endtask : tooth
  always @(posedge clk) begin
    cr = crank;
    cm = cam;
    #1;
    if (due) begin
      if (refd) `CHK(angle.tooth, ang[15:0])
      if (live) `CHK(irq, |(st & msk))
      due = 0;
      teeth_done++;
    end
    if (!reset_n) begin
      pc = 1'b0;
      pm = 1'b0;
    end else begin
      cyc_n++;
      if (cr && !pc) tooth();
      if (cm && !pm) begin
        bank++;
        bflag = 1;
      end
      pc = cr;
      pm = cm;
    end
  end
  // ---------------------------------------------------------------
  // bus and wait helpers
  // ---------------------------------------------------------------
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      wrap_up();
    end
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wait_teeth(input int k);
    int t;
    t = teeth_done + k;
    for (int i = 0; i < k * 100 && teeth_done < t; i++) @(posedge clk);
    if (teeth_done < t) begin
      err_count++;
      wrap_up();
    end
  endtask : wait_teeth
  task automatic pulse_chk(input int by_time);
    int n;
    n = 0;
    while (pulse !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      wrap_up();
    end
    `CHK(angle, 24'h000300)
    n = 0;
    while (pulse === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    // fraction moves one step a clock while the last period is short
    if (by_time) begin
      `CHK(n, 5)
      `CHK(angle, 24'h000305)
    end else begin
      `CHK(angle.tooth, 16'h0005)
    end
  endtask : pulse_chk
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(16));
    {reset_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat, run, extra} = '0;
    ratio = 384;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 64; a += 4) begin
      wb(1'b0, 6'(a), 32'h0);
      `CHK(q, a == 4 ? 32'h180 : (a == 8 || a == 12) ? 32'h3A : a == 16 ? 32'h1 : 32'h0)
    end
    rv = $urandom;
    wb(1'b1, 6'h3C, rv);
    wb(1'b0, 6'h3C, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, `OFS_RATIO, rv);
    wb(1'b0, `OFS_RATIO, 32'h0);
    `CHK(q[15:0], rv[15:0])
    wb(1'b1, `OFS_RATIO, 32'h180);
    wb(1'b1, `OFS_TEETH_EXPECT, 32'hB);
    expct = 11;
    wb(1'b1, `OFS_TEETH_LIMIT, 32'hB);
    lim = 11;
    wb(1'b1, `OFS_MASK, 32'h3);
    msk = 3;
    wb(1'b1, `OFS_CTRL, 32'h1);
    run <= 1'b1;
    wait_teeth(26);
    // start-up teeth leave the counts undefined, so clear before judging
    wb(1'b1, `OFS_STATUS, 32'h3);
    st = 0;
    live = 1;
    wait_teeth(30);
    wb(1'b1, `OFS_TEETH_EXPECT, 32'hA);
    expct = 10;
    wait_teeth(14);
    wb(1'b1, `OFS_MASK, 32'h0);
    msk = 0;
    wait_teeth(3);
    wb(1'b1, `OFS_MASK, 32'h3);
    msk = 3;
    wb(1'b1, `OFS_TEETH_EXPECT, 32'hB);
    expct = 11;
    wb(1'b1, `OFS_STATUS, 32'h3);
    st = 0;
    wb(1'b1, `OFS_TEETH_LIMIT, 32'h8);
    lim = 8;
    wait_teeth(14);
    wb(1'b1, `OFS_TEETH_LIMIT, 32'hB);
    lim = 11;
    wb(1'b1, `OFS_RATIO, 32'h240);
    ratio = 576;
    wait_teeth(28);
    wb(1'b1, `OFS_RATIO, 32'h180);
    ratio = 384;
    wait_teeth(26);
    wb(1'b0, `OFS_PERIOD, 32'h0);
    `CHK(q, {per_old[15:0], per[15:0]})
    wb(1'b1, `OFS_RATIO, 32'hC0);
    ratio = 192;
    wb(1'b1, `OFS_TEETH_EXPECT, 32'hC);
    expct = 12;
    wb(1'b1, `OFS_TEETH_LIMIT, 32'hC);
    lim = 12;
    wb(1'b1, `OFS_CTRL, 32'h3);
    addm = 1;
    extra <= 1'b1;
    wait_teeth(40);
    wb(1'b0, `OFS_BANK, 32'h0);
    `CHK(q[7:0], bank[7:0])
    wb(1'b1, `OFS_RISE_ANGLE, 32'h300);
    wb(1'b1, `OFS_FALL_ANGLE, 32'h500);
    wb(1'b1, `OFS_FALL_DELAY, 32'h5);
    wb(1'b1, `OFS_CTRL, 32'hF);
    pulse_chk(1);
    wb(1'b1, `OFS_CTRL, 32'hB);
    pulse_chk(0);
    wrap_up();
  end
endmodule : tb_crank_angle_tracker
